/* design/ctf_defs.vh */
// constants for the four-channel counter/timer with terminal filters
// assumes an apb slave at 20 mhz, 32-bit data, word-aligned registers
`ifndef CTF_DEFS_VH
`define CTF_DEFS_VH
// ***********************************************
// register byte offsets, per-channel stride 0x20
// ***********************************************
`define CTF_CH_STRIDE      8'h20
`define CTF_OFF_CTRL       8'h00
`define CTF_OFF_COUNT      8'h04
`define CTF_OFF_PULSES     8'h08
`define CTF_OFF_HALFPER    8'h0C
`define CTF_OFF_FIFO       8'h10
`define CTF_OFF_STATUS     8'h14
`define CTF_OFF_AUX        8'h18
`define CTF_OFF_FLT_EN     8'h80
`define CTF_OFF_FLT_SET    8'h84
`define CTF_OFF_FLT_CUST   8'h88
`define CTF_OFF_TERM_DIR   8'h8C
`define CTF_OFF_TERM_OUT   8'h90
`define CTF_OFF_TERM_IN    8'h94
// ***********************************************
// control fields
// ***********************************************
`define CTF_C_MODE_LO      0
`define CTF_C_MODE_HI      2
`define CTF_C_TIMING       3
`define CTF_C_SWARM        4
`define CTF_C_HWARM_EN     5
`define CTF_C_DISARM       6
`define CTF_C_PAUSE_EN     7
`define CTF_C_PAUSE_LVL    8
`define CTF_C_CONT         9
`define CTF_C_RETRIG       10
`define CTF_C_DIR_DOWN     11
`define CTF_C_SRC_LO       12
`define CTF_C_SRC_HI       14
`define CTF_C_GATE_LO      15
`define CTF_C_GATE_HI      17
`define CTF_C_ARM_LO       18
`define CTF_C_ARM_HI       20
`define CTF_C_SCLK_LO      21
`define CTF_C_SCLK_HI      23
`define CTF_C_SW_STOP      24
// ***********************************************
// modes and timing
// ***********************************************
`define CTF_M_EDGE         3'd0
`define CTF_M_PWIDTH       3'd1
`define CTF_M_SEMI         3'd2
`define CTF_M_PERIOD       3'd3
`define CTF_M_POSITION     3'd4
`define CTF_M_PULSE_OUT    3'd5
`define CTF_T_IMPLICIT     1'b0
`define CTF_T_SAMPLED      1'b1
// ***********************************************
// filter settings and timing
// ***********************************************
`define CTF_F_SHORT        2'd0
`define CTF_F_MEDIUM       2'd1
`define CTF_F_HIGH         2'd2
`define CTF_F_CUSTOM       2'd3
`define CTF_CLK_HZ         20000000
`define CTF_FLT_SHORT_PS   112500
`define CTF_FLT_MED_NS     6400
`define CTF_FLT_HIGH_US    2560
`define CTF_SHORT_CYC  (((`CTF_FLT_SHORT_PS*20)+999999)/1000000)
`define CTF_MED_CYC    ((`CTF_FLT_MED_NS*(`CTF_CLK_HZ/1000000))/1000)
`define CTF_HIGH_CYC   ((`CTF_FLT_HIGH_US*(`CTF_CLK_HZ/1000000)))
`define CTF_FIFO_DEPTH     4
`define CTF_FIFO_AW        2
`define CTF_N_TERM         8
`define CTF_N_CH           4
`endif

/* design/ctf_top.v */
// four 32-bit counter/timers with filtered function terminals, apb slave
// assumes terminals are asynchronous and pass a two-flop synchroniser
`timescale 1ns/10ps
`include "ctf_defs.vh"

module ctf_top (
    input  wire        I_CORE_CLK,
    input  wire        I_RST,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    input  wire [7:0]  I_TERM_IN,
    input  wire [3:0]  I_EVENTS,
    output reg  [7:0]  O_TERM_OUT,
    output reg  [7:0]  O_TERM_OE_N,
    output reg         O_FREQ_OUT
);

// ***********************************************
// terminal synchroniser and filters
// ***********************************************
reg  [7:0]  sync1_reg;
reg  [7:0]  sync2_reg;
reg  [7:0]  flt_en_reg;
reg  [15:0] flt_set_reg;
reg  [31:0] flt_cust_reg;
reg  [7:0]  term_dir_reg;
reg  [7:0]  term_out_reg;
reg  [7:0]  filt_reg;
reg  [31:0] flt_div_reg;
wire [7:0]  term_clean;

always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
        sync1_reg <= 8'h00;
        sync2_reg <= 8'h00;
        flt_div_reg <= 32'h0000_0000;
    end else begin
        sync1_reg <= I_TERM_IN;
        sync2_reg <= sync1_reg;
        flt_div_reg <= flt_div_reg + 32'h0000_0001;
    end
end

localparam [31:0] short_cyc = `CTF_SHORT_CYC;
localparam [31:0] med_cyc   = `CTF_MED_CYC;
localparam [31:0] high_cyc  = `CTF_HIGH_CYC;

genvar t;
generate
    for (t = 0; t < `CTF_N_TERM; t = t + 1) begin : g_flt
        reg  [17:0] run_reg;
        reg  [17:0] lim;
        reg         tick;
        always @* begin
            // filter clock: core clock for short, medium and high; custom divider mask tick for custom
            case (flt_set_reg[2*t+1 -: 2])
                `CTF_F_SHORT: begin
                    lim = short_cyc[17:0];
                    tick = 1'b1;
                end
                `CTF_F_MEDIUM: begin
                    lim = med_cyc[17:0];
                    tick = 1'b1;
                end
                `CTF_F_HIGH: begin
                    lim = high_cyc[17:0];
                    tick = 1'b1;
                end
                default: begin
                    lim = {2'b00, flt_cust_reg[15:0]};
                    tick = ((flt_div_reg[15:0] & flt_cust_reg[31:16])
                            == 16'h0000);
                end
            endcase
        end
        always @(posedge I_CORE_CLK or posedge I_RST) begin
            if (I_RST) begin
                run_reg <= 18'h0_0000;
                filt_reg[t] <= 1'b0;
            end else if (!flt_en_reg[t]) begin
                run_reg <= 18'h0_0000;
                filt_reg[t] <= sync2_reg[t];
            end else if (sync2_reg[t] == filt_reg[t]) begin
                run_reg <= 18'h0_0000;
            end else if (tick) begin
                if (run_reg + 18'h0_0001 >= lim) begin
                    filt_reg[t] <= sync2_reg[t];
                    run_reg <= 18'h0_0000;
                end else begin
                    run_reg <= run_reg + 18'h0_0001;
                end
            end
        end
    end
endgenerate
assign term_clean = filt_reg;

// ***********************************************
// counter channels
// ***********************************************
reg  [31:0] ctrl_reg  [0:3];
reg  [31:0] count_reg [0:3];
reg  [31:0] aux_reg   [0:3];
reg  [31:0] pulses_reg[0:3];
reg  [31:0] half_reg  [0:3];
reg  [3:0]  armed_reg;
reg  [3:0]  freq_out_reg;
reg  [31:0] fifo_mem  [0:15];
reg  [2:0]  fifo_cnt_reg [0:3];
reg  [1:0]  fifo_rd_reg  [0:3];
reg  [3:0]  fifo_ovf_reg;
reg  [3:0]  cfg_err_reg;
reg  [3:0]  fifo_pop;
reg  [3:0]  ctrl_wr;
wire [15:0] sel_bus = {I_EVENTS, freq_out_reg, term_clean};

genvar c;
generate
    for (c = 0; c < `CTF_N_CH; c = c + 1) begin : g_ch
        wire [31:0] cr = ctrl_reg[c];
        wire [2:0]  mode = cr[`CTF_C_MODE_HI:`CTF_C_MODE_LO];
        wire src  = sel_bus[{1'b0, cr[`CTF_C_SRC_HI:`CTF_C_SRC_LO]}];
        wire gate = sel_bus[{1'b0, cr[`CTF_C_GATE_HI:`CTF_C_GATE_LO]}];
        wire harm = sel_bus[{1'b0, cr[`CTF_C_ARM_HI:`CTF_C_ARM_LO]}];
        wire sclk = sel_bus[{1'b1, cr[`CTF_C_SCLK_HI:`CTF_C_SCLK_LO]}];
        reg  src_d_reg, gate_d_reg, harm_d_reg, sclk_d_reg;
        reg  running_reg;
        wire src_re  = src & ~src_d_reg;
        wire gate_re = gate & ~gate_d_reg;
        wire gate_ch = gate ^ gate_d_reg;
        wire sclk_re = sclk & ~sclk_d_reg;
        wire paused  = cr[`CTF_C_PAUSE_EN] &
                       (gate == cr[`CTF_C_PAUSE_LVL]);
        // semi-period needs implicit; edge and position need sampled
        wire bad = ((mode == `CTF_M_SEMI) & cr[`CTF_C_TIMING]) |
                   (((mode == `CTF_M_EDGE) | (mode == `CTF_M_POSITION)) &
                    ~cr[`CTF_C_TIMING]);
        wire sample = armed_reg[c] & ~bad &
                      (cr[`CTF_C_TIMING] ? sclk_re :
                       (mode == `CTF_M_SEMI ? gate_ch : gate_re));
        wire [31:0] sval = (mode == `CTF_M_PERIOD) ? aux_reg[c] :
                           count_reg[c];
        wire push = sample & (mode != `CTF_M_PULSE_OUT);
        wire full = (fifo_cnt_reg[c] == 3'd4);
        always @(posedge I_CORE_CLK or posedge I_RST) begin
            if (I_RST) begin
                src_d_reg <= 1'b0;
                gate_d_reg <= 1'b0;
                harm_d_reg <= 1'b0;
                sclk_d_reg <= 1'b0;
                armed_reg[c] <= 1'b0;
                running_reg <= 1'b0;
                count_reg[c] <= 32'h0000_0000;
                aux_reg[c] <= 32'h0000_0000;
                freq_out_reg[c] <= 1'b0;
                fifo_cnt_reg[c] <= 3'd0;
                fifo_rd_reg[c] <= 2'd0;
                fifo_ovf_reg[c] <= 1'b0;
                cfg_err_reg[c] <= 1'b0;
            end else begin
                src_d_reg <= src;
                gate_d_reg <= gate;
                harm_d_reg <= harm;
                sclk_d_reg <= sclk;
                cfg_err_reg[c] <= bad;
                if (ctrl_wr[c] & I_PWDATA[`CTF_C_DISARM]) begin
                    armed_reg[c] <= 1'b0;
                    running_reg <= 1'b0;
                    freq_out_reg[c] <= 1'b0;
                end else if (ctrl_wr[c] & I_PWDATA[`CTF_C_SWARM]) begin
                    armed_reg[c] <= 1'b1;
                    count_reg[c] <= 32'h0000_0000;
                    aux_reg[c] <= 32'h0000_0000;
                end else if (!armed_reg[c] & cr[`CTF_C_HWARM_EN] &
                             harm & ~harm_d_reg) begin
                    armed_reg[c] <= 1'b1;
                    count_reg[c] <= 32'h0000_0000;
                    aux_reg[c] <= 32'h0000_0000;
                end else if (armed_reg[c]) begin
                    case (mode)
                        `CTF_M_EDGE, `CTF_M_POSITION: begin
                            if (src_re & ~paused)
                                count_reg[c] <= cr[`CTF_C_DIR_DOWN] ?
                                    count_reg[c] - 32'h0000_0001 :
                                    count_reg[c] + 32'h0000_0001;
                        end
                        `CTF_M_PWIDTH, `CTF_M_SEMI: begin
                            if (sample & ~cr[`CTF_C_TIMING])
                                count_reg[c] <= 32'h0000_0000;
                            else if (src_re & (gate | mode == `CTF_M_SEMI))
                                count_reg[c] <= count_reg[c] +
                                                32'h0000_0001;
                        end
                        `CTF_M_PERIOD: begin
                            // helper counter holds the last period
                            if (gate_re) begin
                                aux_reg[c] <= count_reg[c];
                                count_reg[c] <= 32'h0000_0000;
                            end else if (src_re)
                                count_reg[c] <= count_reg[c] +
                                                32'h0000_0001;
                        end
                        `CTF_M_PULSE_OUT: begin
                            if (!running_reg) begin
                                if (gate_re) begin
                                    running_reg <= 1'b1;
                                    count_reg[c] <= half_reg[c];
                                    aux_reg[c] <= pulses_reg[c];
                                end
                            end else if (cr[`CTF_C_RETRIG] & gate_re &
                                         ~cr[`CTF_C_CONT]) begin
                                count_reg[c] <= half_reg[c];
                                aux_reg[c] <= pulses_reg[c];
                                freq_out_reg[c] <= 1'b0;
                            end else if (!(cr[`CTF_C_CONT] & paused)) begin
                                if (count_reg[c] != 32'h0000_0000)
                                    count_reg[c] <= count_reg[c] -
                                                    32'h0000_0001;
                                else begin
                                    count_reg[c] <= half_reg[c];
                                    freq_out_reg[c] <= ~freq_out_reg[c];
                                    if (freq_out_reg[c] & ~cr[`CTF_C_CONT])
                                    begin
                                        aux_reg[c] <= aux_reg[c] -
                                                      32'h0000_0001;
                                        if (aux_reg[c] == 32'h0000_0001)
                                            running_reg <= 1'b0;
                                    end
                                end
                            end
                        end
                        default: begin
                            count_reg[c] <= count_reg[c];
                        end
                    endcase
                    if (cr[`CTF_C_CONT] & cr[`CTF_C_SW_STOP]) begin
                        running_reg <= 1'b0;
                        freq_out_reg[c] <= 1'b0;
                    end
                end
                if (push & ~full)
                    fifo_mem[{c[1:0], fifo_rd_reg[c] +
                        fifo_cnt_reg[c][1:0]}] <= sval;
                if (push & full & ~fifo_pop[c])
                    fifo_ovf_reg[c] <= 1'b1;
                else if (ctrl_wr[c] & I_PWDATA[`CTF_C_SWARM])
                    fifo_ovf_reg[c] <= 1'b0;
                if (fifo_pop[c] & fifo_cnt_reg[c] != 3'd0)
                    fifo_rd_reg[c] <= fifo_rd_reg[c] + 2'd1;
                case ({push & ~full,
                       fifo_pop[c] & (fifo_cnt_reg[c] != 3'd0)})
                    2'b10: fifo_cnt_reg[c] <= fifo_cnt_reg[c] + 3'd1;
                    2'b01: fifo_cnt_reg[c] <= fifo_cnt_reg[c] - 3'd1;
                    default: fifo_cnt_reg[c] <= fifo_cnt_reg[c];
                endcase
            end
        end
    end
endgenerate

// ***********************************************
// apb register access
// ***********************************************
wire       acc   = I_PSEL & I_PENABLE & ~O_PREADY;
wire       done  = I_PSEL & I_PENABLE & O_PREADY;
wire [1:0] ch    = I_PADDR[6:5];
wire [4:0] off   = I_PADDR[4:0];
wire       is_ch = ~I_PADDR[7];
reg  [31:0] rd_next;
reg         err_next;
integer k;

always @* begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    fifo_pop = 4'h0;
    ctrl_wr = 4'h0;
    if (is_ch) begin
        case ({3'b000, off})
            `CTF_OFF_CTRL: begin
                rd_next = ctrl_reg[ch];
                ctrl_wr[ch] = done & I_PWRITE;
            end
            `CTF_OFF_COUNT:   rd_next = count_reg[ch];
            `CTF_OFF_PULSES:  rd_next = pulses_reg[ch];
            `CTF_OFF_HALFPER: rd_next = half_reg[ch];
            `CTF_OFF_FIFO: begin
                rd_next = fifo_mem[{ch, fifo_rd_reg[ch]}];
                fifo_pop[ch] = done & ~I_PWRITE;
            end
            `CTF_OFF_STATUS:
                rd_next = {26'h000_0000, cfg_err_reg[ch], fifo_ovf_reg[ch],
                           fifo_cnt_reg[ch], armed_reg[ch]};
            `CTF_OFF_AUX:     rd_next = aux_reg[ch];
            default:          err_next = 1'b1;
        endcase
    end else begin
        case (I_PADDR)
            `CTF_OFF_FLT_EN:   rd_next = {24'h00_0000, flt_en_reg};
            `CTF_OFF_FLT_SET:  rd_next = {16'h0000, flt_set_reg};
            `CTF_OFF_FLT_CUST: rd_next = flt_cust_reg;
            `CTF_OFF_TERM_DIR: rd_next = {24'h00_0000, term_dir_reg};
            `CTF_OFF_TERM_OUT: rd_next = {24'h00_0000, term_out_reg};
            `CTF_OFF_TERM_IN:  rd_next = {24'h00_0000, term_clean};
            default:           err_next = 1'b1;
        endcase
    end
end

always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
        O_PREADY <= 1'b0;
        O_PSLVERR <= 1'b0;
        O_PRDATA <= 32'h0000_0000;
        flt_en_reg <= 8'h00;
        flt_set_reg <= 16'h0000;
        flt_cust_reg <= 32'h0000_0001;
        term_dir_reg <= 8'h00;
        term_out_reg <= 8'h00;
        O_TERM_OUT <= 8'h00;
        O_TERM_OE_N <= 8'hFF;
        O_FREQ_OUT <= 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            ctrl_reg[k] <= 32'h0000_0000;
            pulses_reg[k] <= 32'h0000_0001;
            half_reg[k] <= 32'h0000_0001;
        end
    end else begin
        O_PREADY <= acc;
        O_PSLVERR <= acc & err_next;
        if (acc & ~I_PWRITE)
            O_PRDATA <= rd_next;
        // terminal is an output where dir bit set; bits 0-3 carry counters
        O_TERM_OE_N <= ~term_dir_reg;
        O_TERM_OUT <= {term_out_reg[7:4], freq_out_reg | term_out_reg[3:0]};
        O_FREQ_OUT <= freq_out_reg[0];
        if (done & I_PWRITE & ~err_next) begin
            if (is_ch) begin
                case ({3'b000, off})
                    // arm and disarm bits act once, not stored
                    `CTF_OFF_CTRL: ctrl_reg[ch] <= I_PWDATA &
                                                   32'hFEFF_FFAF;
                    `CTF_OFF_PULSES:  pulses_reg[ch] <= I_PWDATA;
                    `CTF_OFF_HALFPER: half_reg[ch] <= I_PWDATA;
                    default: ctrl_reg[ch] <= ctrl_reg[ch];
                endcase
                if (off == `CTF_OFF_CTRL)
                    ctrl_reg[ch][`CTF_C_SW_STOP] <= I_PWDATA[`CTF_C_SW_STOP];
            end else begin
                case (I_PADDR)
                    `CTF_OFF_FLT_EN:   flt_en_reg <= I_PWDATA[7:0];
                    `CTF_OFF_FLT_SET:  flt_set_reg <= I_PWDATA[15:0];
                    `CTF_OFF_FLT_CUST: flt_cust_reg <= I_PWDATA;
                    `CTF_OFF_TERM_DIR: term_dir_reg <= I_PWDATA[7:0];
                    `CTF_OFF_TERM_OUT: term_out_reg <= I_PWDATA[7:0];
                    default: term_out_reg <= term_out_reg;
                endcase
            end
        end
    end
end

endmodule // ctf_top

/* verif/ctf_term_model.sv */
// terminal model: external timing levels on the eight terminals
// assumes its tasks are entered right after a rising clock edge
`timescale 1ns/10ps
module ctf_term_model (
    input  wire        i_clk,
    output logic [7:0] o_term
);
    // ****************
    // level driving
    // ****************
    initial o_term = 8'h00;
    task automatic drive(input int b, input logic v);
        o_term[b] <= v;
        @(posedge i_clk);
    endtask
    task automatic pulses(input int b, input int n, input int w);
        repeat (n) begin
            drive(b, 1'b1);
            repeat (w - 1) @(posedge i_clk);
            drive(b, 1'b0);
            repeat (w - 1) @(posedge i_clk);
        end
    endtask
endmodule // ctf_term_model

/* verif/ctf_top_chk.sv */
// checker for ctf_top: apb answer timing and terminal port levels
// assumes it is bound to ctf_top and sees only its ports
`timescale 1ns/10ps
`include "ctf_defs.vh"
module ctf_top_chk (
    input wire        I_CORE_CLK,
    input wire        I_RST,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [7:0]  I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire [7:0]  I_TERM_IN,
    input wire [3:0]  I_EVENTS,
    input wire [7:0]  O_TERM_OUT,
    input wire [7:0]  O_TERM_OE_N,
    input wire        O_FREQ_OUT
);
    // ****************
    // checks
    // ****************
    logic       wr_seen;
    logic [7:0] dir_q;
    wire        wr_done = O_PREADY && I_PSEL && I_PWRITE;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            wr_seen <= 1'b0;
            dir_q   <= 8'h00;
        end else if (wr_done) begin
            wr_seen <= 1'b1;
            if (I_PADDR == `CTF_OFF_TERM_DIR) dir_q <= I_PWDATA[7:0];
        end
    end
    property p_ready_wait;
        I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready late");
    property p_ready_pulse;
        O_PREADY |=> !O_PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready too long");
    property p_ready_cause;
        $rose(O_PREADY) |-> $past(I_PSEL && I_PENABLE);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without access");
    property p_err_rd;
        O_PSLVERR |-> O_PREADY && (I_PWRITE || O_PRDATA == 32'h0000_0000);
    endproperty
    a_err_rd: assert property (p_err_rd)
        else $error("refused answer wrong");
    property p_unmapped;
        O_PREADY && I_PADDR[7] |-> O_PSLVERR ==
            (I_PADDR[6:0] > 7'h14 || I_PADDR[1:0] != 2'b00);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("global map error flag wrong");
    property p_freq_idle;
        !wr_seen |-> !O_FREQ_OUT && O_TERM_OUT == 8'h00;
    endproperty
    a_freq_idle: assert property (p_freq_idle)
        else $error("output before configuration");
    property p_oe_idle;
        !wr_seen |-> O_TERM_OE_N == 8'hFF;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("terminal driven after reset");
    property p_oe_dir;
        wr_done && I_PADDR == `CTF_OFF_TERM_DIR
            |=> ##[0:2] O_TERM_OE_N == ~dir_q;
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("direction not applied");
    cover property (O_PSLVERR);
    cover property (wr_done && I_PADDR == `CTF_OFF_CTRL);
    cover property (O_PREADY && I_PADDR == `CTF_OFF_TERM_IN);
endmodule // ctf_top_chk
bind ctf_top ctf_top_chk i_ctf_top_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_TERM_IN(I_TERM_IN), .I_EVENTS(I_EVENTS),
    .O_TERM_OUT(O_TERM_OUT), .O_TERM_OE_N(O_TERM_OE_N),
    .O_FREQ_OUT(O_FREQ_OUT)
);

/* verif/testbench.sv */
// self-checking bench for ctf_top: apb master, terminal model, queue
// assumes a one-cycle ready answer to every apb transfer
`timescale 1ns/10ps
`include "ctf_defs.vh"
module testbench;
    // ****************
    // signals
    // ****************
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [3:0]  events   = 4'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [7:0]  term_in;
    wire  [7:0]  term_out;
    wire  [7:0]  term_oe_n;
    wire         freq_out;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] v;
    integer      seed = 32'hc814;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          k;
    int          rises = 0;
    logic        fo_q = 1'b0;
    int          nf[3] = '{3, 128, 5};
    logic [1:0]  fs[3] = '{`CTF_F_SHORT, `CTF_F_MEDIUM, `CTF_F_CUSTOM};
    localparam logic [31:0] edge_cfg = (32'h1 << `CTF_C_SRC_LO)
                                     | (32'h1 << `CTF_C_TIMING);
    localparam logic [31:0] down = 32'h1 << `CTF_C_DIR_DOWN;
    localparam logic [31:0] pause = (32'h1 << `CTF_C_PAUSE_EN)
        | (32'h1 << `CTF_C_PAUSE_LVL) | (32'h2 << `CTF_C_GATE_LO);
    always #25 core_clk = ~core_clk;
    ctf_top i_ctf_top (
        .I_CORE_CLK(core_clk), .I_RST(rst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_TERM_IN(term_in), .I_EVENTS(events),
        .O_TERM_OUT(term_out), .O_TERM_OE_N(term_oe_n),
        .O_FREQ_OUT(freq_out)
    );
    ctf_term_model i_ctf_term_model (.i_clk(core_clk), .o_term(term_in));
    // ****************
    // tasks
    // ****************
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        exp_q.push_back({~w, err, d});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        fo_q <= freq_out;
        if (freq_out === 1'b1 && fo_q === 1'b0) rises++;
    end
    always @(posedge core_clk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            check(pslverr === e[32] && (e[33] !== 1'b1
                  || prdata === e[31:0]), "apb answer");
        end
    end
    // ****************
    // sequence
    // ****************
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(term_oe_n === 8'hFF && term_out === 8'h00, "idle");
        apb(1'b0, `CTF_OFF_FLT_EN, 32'h0000_0000, 1'b0);
        apb(1'b1, 8'hF0, 32'h0000_00FF, 1'b1);
        apb(1'b0, 8'hFC, 32'h0000_0000, 1'b1);
        v = $random(seed);
        apb(1'b1, `CTF_OFF_TERM_DIR, {24'h00_0000, v[7:0]}, 1'b0);
        apb(1'b1, `CTF_OFF_TERM_OUT, {24'h00_0000, v[15:8]}, 1'b0);
        apb(1'b0, `CTF_OFF_TERM_DIR, {24'h00_0000, v[7:0]}, 1'b0);
        check(term_oe_n === ~v[7:0] && term_out === v[15:8], "dir");
        apb(1'b1, `CTF_OFF_TERM_DIR, 32'h0000_0000, 1'b0);
        apb(1'b1, `CTF_OFF_FLT_CUST, 32'h0000_0005, 1'b0);
        apb(1'b1, `CTF_OFF_FLT_EN, 32'h0000_0001, 1'b0);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, `CTF_OFF_FLT_SET, {30'h0, fs[k]}, 1'b0);
            i_ctf_term_model.pulses(0, 1, nf[k] - 1);
            repeat (8) @(posedge core_clk);
            apb(1'b0, `CTF_OFF_TERM_IN, 32'h0000_0000, 1'b0);
            i_ctf_term_model.drive(0, 1'b1);
            repeat (nf[k] + 4) @(posedge core_clk);
            apb(1'b0, `CTF_OFF_TERM_IN, 32'h0000_0001, 1'b0);
            i_ctf_term_model.drive(0, 1'b0);
            repeat (nf[k] + 4) @(posedge core_clk);
        end
        apb(1'b1, `CTF_OFF_FLT_EN, 32'h0000_0000, 1'b0);
        apb(1'b1, `CTF_OFF_CTRL, edge_cfg, 1'b0);
        i_ctf_term_model.pulses(1, 3, 4);
        apb(1'b0, `CTF_OFF_COUNT, 32'h0000_0000, 1'b0);
        k = 1 + ($unsigned($random(seed)) % 4);
        v = edge_cfg | down | (32'h1 << `CTF_C_SWARM);
        apb(1'b1, `CTF_OFF_CTRL, v, 1'b0);
        i_ctf_term_model.pulses(1, k, 4);
        apb(1'b0, `CTF_OFF_COUNT, 32'h0000_0000 - k, 1'b0);
        i_ctf_term_model.drive(2, 1'b1);
        apb(1'b1, `CTF_OFF_CTRL, edge_cfg | down | pause, 1'b0);
        i_ctf_term_model.pulses(1, 2, 4);
        apb(1'b0, `CTF_OFF_COUNT, 32'h0000_0000 - k, 1'b0);
        i_ctf_term_model.drive(2, 1'b0);
        repeat (4) @(posedge core_clk);
        i_ctf_term_model.pulses(1, 2, 4);
        apb(1'b0, `CTF_OFF_COUNT, 32'h0000_0000 - k - 2, 1'b0);
        v = edge_cfg | (32'h4 << `CTF_C_SCLK_LO) | (32'h1 << `CTF_C_SWARM);
        apb(1'b1, `CTF_OFF_CTRL, v, 1'b0);
        i_ctf_term_model.pulses(1, 2, 4);
        events <= 4'h1;
        @(posedge core_clk);
        events <= 4'h0;
        apb(1'b0, `CTF_OFF_STATUS, 32'h0000_0003, 1'b0);
        apb(1'b0, `CTF_OFF_FIFO, 32'h0000_0002, 1'b0);
        apb(1'b1, `CTF_OFF_HALFPER, 32'h0000_0001, 1'b0);
        apb(1'b1, `CTF_OFF_PULSES, 32'h0000_0002, 1'b0);
        v = `CTF_M_PULSE_OUT | (32'h3 << `CTF_C_GATE_LO)
          | (32'h1 << `CTF_C_SWARM);
        apb(1'b1, `CTF_OFF_CTRL, v, 1'b0);
        k = rises;
        i_ctf_term_model.drive(3, 1'b1);
        repeat (20) @(posedge core_clk);
        check(rises == k + 2 && freq_out === 1'b0, "pulses");
        check(exp_q.size() == 0, "answers missing");
        report_and_stop();
    end
endmodule // testbench
